// ---- rtl/pmx_pkg.sv ----
// shared constants and types for the pad multiplexer
package pmx_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NPAD    = 46;  // chip pads
  localparam int unsigned NFUNC   = 4;   // output function candidates per pad
  localparam int unsigned NGPIO   = 8;   // core-driven general purpose pads
  localparam int unsigned NIRQ    = 8;   // external interrupt pads
  localparam int unsigned NMST    = 3;   // host core, application processor, debugger
  localparam int unsigned PR_W    = 13;  // stored bits of a pad control word

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_PAD_BASE = 32'h4000_4C00;  // first_pad_control
  localparam logic [31:0] ADDR_PAD_LAST = 32'h4000_4DAC;  // beyond the last pad word 0x40004CB4
  localparam logic [31:0] ADDR_GSEL     = 32'h4000_4D60;  // gpio_pad_select
  localparam logic [31:0] ADDR_GIN      = 32'h4000_5100;  // gpio_input_value
  localparam logic [31:0] ADDR_GOUT     = 32'h4000_5104;  // gpio_output_value
  localparam logic [31:0] ADDR_STEP     = 32'h0000_0004;

  // ----------------------------------------------------------------
  // pad control word layout
  // ----------------------------------------------------------------
  localparam int unsigned FSEL_LSB = 0;   // output function select [1:0]
  localparam int unsigned CSEL_LSB = 3;   // control source select [4:3]
  localparam int unsigned CTL_LSB  = 5;   // driver controls [12:5]
  localparam logic [PR_W-1:0] PAD_MASK = 13'h1FFB;  // bit 2 unused
  localparam logic [PR_W-1:0] PAD_RST  = 13'h0160;  // oen=1 pull=up drive=4mA

  // control source encodings
  localparam logic [1:0] CS_REG  = 2'h0;
  localparam logic [1:0] CS_PERI = 2'h1;
  localparam logic [1:0] CS_FAB  = 2'h2;

  // gpio_pad_select: [7:0] gpio drive enable, [15:8] irq route (1 = sensor engine)
  localparam int unsigned GSEL_IRQ_LSB = 8;
  localparam logic [15:0] GSEL_RST     = 16'h0000;

  // fixed pad numbers of the gpio and interrupt pads
  localparam int unsigned GPIO_PAD [NGPIO] = '{8, 9, 10, 11, 12, 13, 14, 15};
  localparam int unsigned IRQ_PAD  [NIRQ]  = '{2, 3, 4, 5, 6, 7, 16, 17};

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       smt;     // schmitt trigger
    logic       ren;     // receive enable
    logic       sr;      // slew rate fast
    logic [1:0] drive;   // drive strength code
    logic [1:0] pull;    // pull / keeper code
    logic       oen;     // active low output enable
  } pmx_padctl_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pmx_req_t;

endpackage

// ---- rtl/pmx_top.sv ----
// pad multiplexer: per pad function and control selection, input gating, gpio
//
// Notes on behaviour
// - 46 pads, each usable as input, output or bidirectional.
// - pad control bits [1:0] pick the function driving the pad output.
// - driver controls come from register bits [12:5], a peripheral, or fabric.
// - sampled pad values are gated by receive enable and routed inward.
// - pad control block spans 0x40004C00 to 0x40004CB4.
// - all pad control registers share one layout and behaviour.
// - host core, application processor and debugger can read and write them.
// - fabric has no write path; a bus master configures pads first.
// - registers return to reset values on chip reset.
// - eight gpio pads driven and sampled through select, input, output registers.
// - fabric can drive and sample any pad once selections are programmed.
// - eight interrupt pads route to core or sensor engine.
// - eight pads can carry internal monitor signals, including clocks.
// - exactly one of four functions drives each pad output, except a gpio pad enabled in gpio_pad_select.
// - output enable bit 5 is active low, resets to 1 (driver off).
// - source field 4:3: 0 register, 1 peripheral, 2 fabric.
`timescale 1ns/10ps
`default_nettype none

module pmx_top
  import pmx_pkg::*;
(
  // clock and reset
  input  wire logic                                    clk,
  input  wire logic                                    rst_n,
  input  wire logic                                    ce,
  // register masters: 0 host core, 1 application processor, 2 debugger
  input  wire pmx_pkg::pmx_req_t [pmx_pkg::NMST-1:0]   mst_req,
  output logic [pmx_pkg::NMST-1:0]                     mst_ack,
  output logic [31:0]                                  mst_rdata,
  // function candidates, including monitor signals
  input  wire logic [pmx_pkg::NPAD-1:0][pmx_pkg::NFUNC-1:0] func_out,
  // driver controls from peripherals and fabric
  input  wire pmx_pkg::pmx_padctl_t [pmx_pkg::NPAD-1:0] peri_ctl,
  input  wire pmx_pkg::pmx_padctl_t [pmx_pkg::NPAD-1:0] fab_ctl,
  // pad pins
  input  wire logic [pmx_pkg::NPAD-1:0]                pad_in,
  output logic [pmx_pkg::NPAD-1:0]                     pad_out,
  output logic [pmx_pkg::NPAD-1:0]                     pad_oe,
  output pmx_pkg::pmx_padctl_t [pmx_pkg::NPAD-1:0]     pad_ctl,
  // inward pad values and interrupts
  output logic [pmx_pkg::NPAD-1:0]                     pad_in_q,
  output logic [pmx_pkg::NIRQ-1:0]                     irq_core,
  output logic [pmx_pkg::NIRQ-1:0]                     irq_sens
);
  import pmx_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NPAD-1:0][PR_W-1:0] pad;
    logic [15:0]               gsel;
    logic [NGPIO-1:0]          gout;
    logic [NPAD-1:0]           dout;
    logic [NPAD-1:0]           oe;
    pmx_padctl_t [NPAD-1:0]    ctl;
    logic [NPAD-1:0]           pin;
    logic [NIRQ-1:0]           irqc;
    logic [NIRQ-1:0]           irqs;
    logic [NMST-1:0]           ack;
    logic [31:0]               rdata;
  } pmx_state_t;

  pmx_state_t st_q;
  pmx_state_t st_d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    pmx_req_t    acc;
    logic        hit;
    logic [1:0]  csel;
    pmx_padctl_t sel;
    logic [NGPIO-1:0] gin;
    st_d  = st_q;
    acc   = '0;
    hit   = 1'b0;
    csel  = 2'h0;
    sel   = '0;
    gin   = '0;
    st_d.ack = '0;
    // fixed priority, lowest index wins; fabric has no request port
    for (int m = NMST - 1; m >= 0; m--) begin
      if (mst_req[m].valid) begin
        acc = mst_req[m];
        st_d.ack = '0;
        st_d.ack[m] = 1'b1;
      end
    end
    for (int k = 0; k < NGPIO; k++) begin
      gin[k] = st_q.pin[GPIO_PAD[k]];
    end
    // register read and write decode
    st_d.rdata = 32'h0000_0000;
    if (acc.valid) begin
      for (int i = 0; i < NPAD; i++) begin
        if (acc.addr == ADDR_PAD_BASE + ADDR_STEP * 32'(i)) begin
          hit = 1'b1;
          st_d.rdata = {19'h0, st_q.pad[i]};
          if (acc.write) begin
            st_d.pad[i] = acc.wdata[PR_W-1:0] & PAD_MASK;
          end
        end
      end
      if (!hit && acc.addr == ADDR_GSEL) begin
        st_d.rdata = {16'h0, st_q.gsel};
        if (acc.write) begin
          st_d.gsel = acc.wdata[15:0];
        end
      end else if (!hit && acc.addr == ADDR_GIN) begin
        st_d.rdata = {24'h0, gin};
      end else if (!hit && acc.addr == ADDR_GOUT) begin
        st_d.rdata = {24'h0, st_q.gout};
        if (acc.write) begin
          st_d.gout = acc.wdata[NGPIO-1:0];
        end
      end
    end
    // per pad output and control selection, from current settings
    for (int i = 0; i < NPAD; i++) begin
      csel = st_q.pad[i][CSEL_LSB +: 2];
      unique case (csel)
        CS_PERI: sel = peri_ctl[i];
        CS_FAB:  sel = fab_ctl[i];
        default: sel = pmx_padctl_t'(st_q.pad[i][PR_W-1:CTL_LSB]);
      endcase
      st_d.ctl[i]  = sel;
      st_d.oe[i]   = !sel.oen;
      // one of four candidates, monitors among them
      st_d.dout[i] = func_out[i][st_q.pad[i][FSEL_LSB +: 2]];
      st_d.pin[i]  = pad_in[i] & sel.ren;
    end
    // gpio pads take the core's output value when selected
    for (int k = 0; k < NGPIO; k++) begin
      if (st_q.gsel[k]) begin
        st_d.dout[GPIO_PAD[k]] = st_q.gout[k];
      end
    end
    // interrupt pad routing
    for (int k = 0; k < NIRQ; k++) begin
      st_d.irqc[k] = st_q.pin[IRQ_PAD[k]] & !st_q.gsel[GSEL_IRQ_LSB + k];
      st_d.irqs[k] = st_q.pin[IRQ_PAD[k]] &  st_q.gsel[GSEL_IRQ_LSB + k];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q      <= '0;
      st_q.gsel <= GSEL_RST;
      for (int i = 0; i < NPAD; i++) begin
        st_q.pad[i] <= PAD_RST;
        st_q.ctl[i] <= pmx_padctl_t'(PAD_RST[PR_W-1:CTL_LSB]);
      end
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // outputs straight from state
  assign mst_ack   = st_q.ack;
  assign mst_rdata = st_q.rdata;
  assign pad_out   = st_q.dout;
  assign pad_oe    = st_q.oe;
  assign pad_ctl   = st_q.ctl;
  assign pad_in_q  = st_q.pin;
  assign irq_core  = st_q.irqc;
  assign irq_sens  = st_q.irqs;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  reset_value_a: assert property (@(posedge clk)
    !$past(rst_n) && rst_n |-> st_q.pad[0] == PAD_RST && !pad_oe[0])
    else $error("pad control not at reset value");

  reg_oe_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && st_q.pad[0][CSEL_LSB +: 2] == CS_REG
      |=> pad_oe[0] == !$past(st_q.pad[0][CTL_LSB]))
    else $error("register output enable not followed");

  fabric_ctl_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && st_q.pad[1][CSEL_LSB +: 2] == CS_FAB |=> pad_ctl[1] == $past(fab_ctl[1]))
    else $error("fabric controls not selected");

  peri_ctl_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && st_q.pad[1][CSEL_LSB +: 2] == CS_PERI |=> pad_ctl[1] == $past(peri_ctl[1]))
    else $error("peripheral controls not selected");

  func_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> pad_out[0] == $past(func_out[0][st_q.pad[0][FSEL_LSB +: 2]]))
    else $error("wrong function drives pad");

  write_upd_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && mst_req[0].valid && mst_req[0].write && mst_req[0].addr == ADDR_PAD_BASE
      |=> mst_ack[0] && st_q.pad[0] == ($past(mst_req[0].wdata[PR_W-1:0]) & PAD_MASK))
    else $error("pad write not applied");

  input_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> pad_in_q[0] == ($past(pad_in[0]) && pad_ctl[0].ren))
    else $error("input passed while receive disabled");

  gpio_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && st_q.gsel[0] |=> pad_out[GPIO_PAD[0]] == $past(st_q.gout[0]))
    else $error("gpio value not on pad");

  irq_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> irq_core[0] == ($past(pad_in_q[IRQ_PAD[0]]) && !$past(st_q.gsel[GSEL_IRQ_LSB]))
      && !(irq_core[0] && irq_sens[0]))
    else $error("interrupt routed wrongly");

  master_grant_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && mst_req[0].valid && mst_req[2].valid |=> mst_ack[0] && !mst_ack[2])
    else $error("priority between masters broken");

endmodule

`default_nettype wire

// ---- tb/pmx_board.sv ----
// board side of the pads: external drivers and pull levels
`timescale 1ns/10ps
`default_nettype none

module pmx_board
  import pmx_pkg::*;
(
  // chip side of the pads
  input  wire logic [pmx_pkg::NPAD-1:0]                 pad_out,
  input  wire logic [pmx_pkg::NPAD-1:0]                 pad_oe,
  input  wire pmx_pkg::pmx_padctl_t [pmx_pkg::NPAD-1:0] pad_ctl,
  // board drivers
  input  wire logic [pmx_pkg::NPAD-1:0]                 ext_val,
  input  wire logic [pmx_pkg::NPAD-1:0]                 ext_en,
  // resolved pad level
  output logic [pmx_pkg::NPAD-1:0]                      pad_in
);
  import pmx_pkg::*;

  // chip driver first, then board driver, then pull; a floating pad shows the inverse level
  always_comb begin
    for (int i = 0; i < NPAD; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                  (pad_ctl[i].pull == 2'h1) ? 1'b1 :
                  (pad_ctl[i].pull == 2'h2) ? 1'b0 : ~ext_val[i];
    end
  end
endmodule

`default_nettype wire

// ---- tb/test_pmx_top.sv ----
// self-checking bench for the pad multiplexer
`timescale 1ns/10ps
`default_nettype none

module test_pmx_top;
  import pmx_pkg::*;

  logic                       clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic                       ce = 1'b1;
  pmx_req_t [NMST-1:0]        mst_req = '0;
  logic [NMST-1:0]            mst_ack;
  logic [31:0]                mst_rdata;
  logic [NPAD-1:0][NFUNC-1:0] func_out = '0;
  pmx_padctl_t [NPAD-1:0]     peri_ctl = '0;
  pmx_padctl_t [NPAD-1:0]     fab_ctl = '0;
  pmx_padctl_t [NPAD-1:0]     pad_ctl;
  logic [NPAD-1:0]            pad_in, pad_out, pad_oe, pad_in_q;
  logic [NPAD-1:0]            ext_val = '0;
  logic [NPAD-1:0]            ext_en = '0;
  logic [NIRQ-1:0]            irq_core, irq_sens;
  logic [31:0]                rd;
  int                         err_count = 0;
  int                         checks_done = 0;

  // clock of 100 ns
  always #50 clk = ~clk;

  pmx_top uut (.clk(clk), .rst_n(rst_n), .ce(ce), .mst_req(mst_req), .mst_ack(mst_ack),
    .mst_rdata(mst_rdata), .func_out(func_out), .peri_ctl(peri_ctl), .fab_ctl(fab_ctl),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_ctl(pad_ctl),
    .pad_in_q(pad_in_q), .irq_core(irq_core), .irq_sens(irq_sens));

  pmx_board board (.pad_out(pad_out), .pad_oe(pad_oe), .pad_ctl(pad_ctl),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

  // compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one register access; valid held until the ack edge, one idle edge after
  task automatic acc(input int m, input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    mst_req[m] <= '{1'b1, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (mst_ack[m] !== 1'b1 && n < 20);
    chk(64'(mst_ack[m]), 64'h1);
    rd = mst_rdata;
    mst_req[m].valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input int m, input logic [31:0] a, input logic [31:0] e);
    acc(m, 1'b0, a, 32'h0);
    chk(64'(rd), 64'(e));
  endtask

  function automatic logic [31:0] pa(input int i);
    return ADDR_PAD_BASE + ADDR_STEP * 32'(i);
  endfunction

  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  // test sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(0, pa(0), 32'h160);
    rdchk(2, pa(45), 32'h160);
    rdchk(1, ADDR_GSEL, 32'h0);
    rdchk(0, ADDR_PAD_LAST + ADDR_STEP, 32'h0);
    chk(64'(pad_oe), 64'h0);
    chk(64'(pad_ctl[0]), 64'h0B);
    $display("test reset done");
    // pad functions are settled before any pad word is written
    func_out[0] <= 4'hA;
    for (int s = 0; s < 4; s++) begin
      acc(0, 1'b1, pa(0), 32'h140 | 32'(s));
      settle();
      chk(64'(pad_out[0]), 64'((4'hA >> s) & 4'h1));
      chk(64'(pad_oe[0]), 64'h1);
      chk(64'(pad_ctl[5]), 64'h0B);
    end
    acc(2, 1'b1, pa(3), 32'hFFFF_FFFF);
    rdchk(1, pa(3), 32'h1FFB);
    settle();
    chk(64'(pad_ctl[3]), 64'hFF);
    $display("test function select done");
    peri_ctl[1] <= 8'h5A;
    fab_ctl[1] <= 8'hA5;
    acc(0, 1'b1, pa(1), 32'h168);
    settle();
    chk(64'({pad_oe[1], pad_ctl[1]}), 64'({1'b1, 8'h5A}));
    acc(1, 1'b1, pa(1), 32'h170);
    settle();
    chk(64'({pad_oe[1], pad_ctl[1]}), 64'({1'b0, 8'hA5}));
    $display("test control source done");
    ext_en[20] <= 1'b1;
    ext_val[20] <= 1'b1;
    acc(0, 1'b1, pa(20), 32'h960);
    settle();
    chk(64'(pad_in_q[20]), 64'h1);
    ext_val[20] <= 1'b0;
    settle();
    chk(64'(pad_in_q[20]), 64'h0);
    acc(0, 1'b1, pa(20), 32'h160);
    ext_val[20] <= 1'b1;
    settle();
    chk(64'(pad_in_q[20]), 64'h0);
    $display("test input gating done");
    ext_en[IRQ_PAD[0]] <= 1'b1;
    ext_val[IRQ_PAD[0]] <= 1'b1;
    acc(0, 1'b1, pa(IRQ_PAD[0]), 32'h960);
    settle();
    chk(64'({irq_core[0], irq_sens[0]}), 64'h2);
    acc(0, 1'b1, ADDR_GSEL, 32'h100);
    settle();
    chk(64'({irq_core[0], irq_sens[0]}), 64'h1);
    $display("test interrupt route done");
    acc(0, 1'b1, pa(GPIO_PAD[1]), 32'h960);
    settle();
    rdchk(0, ADDR_GIN, 32'h2);
    acc(0, 1'b1, ADDR_GIN, 32'hFF);
    rdchk(0, ADDR_GIN, 32'h2);
    acc(0, 1'b1, ADDR_GSEL, 32'hFF);
    acc(0, 1'b1, ADDR_GOUT, 32'hA5);
    rdchk(2, ADDR_GOUT, 32'hA5);
    settle();
    chk(64'(pad_out[15:8]), 64'hA5);
    $display("test gpio done");
    // clock enable low freezes the pad outputs
    ce <= 1'b0;
    func_out[0] <= 4'h0;
    settle();
    chk(64'(pad_out[0]), 64'h1);
    ce <= 1'b1;
    settle();
    chk(64'(pad_out[0]), 64'h0);
    $display("test clock enable done");
    // two masters request in the same cycle; host core goes first
    fork
      acc(0, 1'b1, pa(30), 32'h161);
      acc(2, 1'b1, pa(31), 32'h162);
    join
    rdchk(1, pa(30), 32'h161);
    rdchk(1, pa(31), 32'h162);
    $display("test master contention done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(0, pa(20), 32'h160);
    rdchk(0, ADDR_GSEL, 32'h0);
    chk(64'(pad_oe), 64'h0);
    $display("test second reset done");
    end_of_test();
  end
endmodule

`default_nettype wire
